// [design/alu_core.sv]
// registered alu slice: abs, add, add immediate, and, flags, apb slave
//
// How it works
// [RULE_01] alu and shift opcodes are 4-bit nibbles paired in one byte
// [RULE_02] other groups use a whole 8-bit opcode on their own
// [RULE_03] add and and results shift by the upper nibble code, else pass
// [RULE_04] abs picks inverted s plus carry-in when s negative, else s
// [RULE_05] controller must set carry-in high when issuing abs
// [RULE_06] abs drives the sign of s on the sign/status flag pin
// [RULE_07] abs overflow when top byte 80 hex and other bytes 00 hex
// [RULE_08] add sums r, s and carry-in into alu and mq shifters
// [RULE_09] carry before shift; zero, negative after; overflow both
// [RULE_10] add flags: zero, msb negative, signed overflow, carry-out
// [RULE_11] high carry-in adds one to the sum, low leaves plain sum
// [RULE_12] add immediate uses 0..15 from low a-address inputs as r
// [RULE_13] and combines r and s bitwise into alu and mq shifters
// [RULE_14] controller selects 32-bit word mode with configuration 110
// [RULE_15] abs: zero on zero result, negative from input, carry if s zero
// [RULE_16] abs and add immediate never shift; byte selects ignored
// [RULE_17] s operand from register word, b data port or mq register
`timescale 1ns/10ps
module alu_core (
   input wire logic pclk, // 200 MHz bus clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [alu_pkg::ADDR_W-1:0] paddr, // apb byte address
   input wire logic [alu_pkg::DATA_W-1:0] pwdata, // apb write data
   output logic [alu_pkg::DATA_W-1:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // unmapped address
   output logic sign_shift_flag_pin, // sign/status flag
   output logic irq // level interrupt
);
   localparam int unsigned W = alu_pkg::DATA_W;

   logic [alu_pkg::CTRL_W-1:0] ctrl_r;
   logic [W-1:0] a_data_r, b_data_r, rf_word_r, mq_r, result_r;
   logic [alu_pkg::FLAG_W-1:0] flags_r;
   logic [alu_pkg::IRQ_W-1:0] irq_stat_r, irq_mask_r;
   logic exec_r, pready_r, pslverr_r, irq_r, sign_r;
   logic [W-1:0] prdata_r;

   // bus decode
   wire acc = psel & penable & ~pready_r;
   wire wr = acc & pwrite;
   wire hit_ctrl = paddr == alu_pkg::OFF_CTRL;
   wire hit_rdata = paddr == alu_pkg::OFF_RDATA;
   wire hit_sdata = paddr == alu_pkg::OFF_SDATA;
   wire hit_rf = paddr == alu_pkg::OFF_RFWORD;
   wire hit_res = paddr == alu_pkg::OFF_RESULT;
   wire hit_flags = paddr == alu_pkg::OFF_FLAGS;
   wire hit_mq = paddr == alu_pkg::OFF_MQ;
   wire hit_stat = paddr == alu_pkg::OFF_IRQ_STAT;
   wire hit_mask = paddr == alu_pkg::OFF_IRQ_MASK;
   wire mapped = hit_ctrl | hit_rdata | hit_sdata | hit_rf | hit_res |
                 hit_flags | hit_mq | hit_stat | hit_mask;
   wire [W-1:0] rd_mux =
      hit_ctrl ? {{(W-alu_pkg::CTRL_W){1'b0}}, ctrl_r} :
      hit_rdata ? a_data_r :
      hit_sdata ? b_data_r :
      hit_rf ? rf_word_r :
      hit_res ? result_r :
      hit_flags ? {{(W-alu_pkg::FLAG_W){1'b0}}, flags_r} :
      hit_mq ? mq_r :
      hit_stat ? {{(W-alu_pkg::IRQ_W){1'b0}}, irq_stat_r} :
      hit_mask ? {{(W-alu_pkg::IRQ_W){1'b0}}, irq_mask_r} : '0;

   // control word fields
   wire [7:0] op = ctrl_r[alu_pkg::F_OP_HI:alu_pkg::F_OP_LO];
   wire [3:0] alu_code = op[3:0];
   wire [3:0] sh_code = op[7:4];
   wire cin = ctrl_r[alu_pkg::F_CIN];
   wire [1:0] s_sel = ctrl_r[alu_pkg::F_SSEL_HI:alu_pkg::F_SSEL_LO];
   wire [2:0] cfg = ctrl_r[alu_pkg::F_CFG_HI:alu_pkg::F_CFG_LO];
   wire [3:0] low_a = ctrl_r[alu_pkg::F_IMM_HI:alu_pkg::F_IMM_LO];
   wire ld_mq = ctrl_r[alu_pkg::F_LDMQ];

   // full-byte opcodes are matched before nibble pairs
   wire is_abs = op == alu_pkg::OP_ABS; // [RULE_02]
   wire is_add_immediate_op = op == alu_pkg::OP_ADD_IMMEDIATE_OP; // [RULE_02]
   wire full_op = is_abs | is_add_immediate_op;
   wire is_add = ~full_op & (alu_code == alu_pkg::ALU_ADD); // [RULE_01]
   wire is_and = ~full_op & (alu_code == alu_pkg::ALU_AND); // [RULE_01]
   wire legal = is_abs | is_add_immediate_op | is_add | is_and;
   wire shiftable = is_add | is_and; // [RULE_16]

   // operand muxes
   wire [W-1:0] s_op = (s_sel == alu_pkg::SSEL_RF) ? rf_word_r :
                       (s_sel == alu_pkg::SSEL_MQ) ? mq_r :
                       b_data_r; // [RULE_17]
   wire [W-1:0] r_op = is_add_immediate_op ? {{(W-4){1'b0}}, low_a} : a_data_r; // [RULE_12]

   // abs: negative inputs rely on carry-in held high by the controller
   wire [W-1:0] abs_sum = ~s_op + {{(W-1){1'b0}}, cin}; // [RULE_04]
   wire [W-1:0] abs_res = s_op[W-1] ? abs_sum : s_op; // [RULE_04]
   wire abs_ovr = (s_op[W-1:W-8] == alu_pkg::MS_BYTE_MIN) &
                  (s_op[W-9:0] == alu_pkg::LOW_BYTES_ZERO); // [RULE_07]

   // adder shared by add and add immediate
   wire [W:0] add_full = {1'b0, r_op} + {1'b0, s_op} +
                         {{W{1'b0}}, cin}; // [RULE_08] [RULE_11]
   wire [W-1:0] add_sum = add_full[W-1:0];
   wire add_c = add_full[W];
   wire add_ovr = (r_op[W-1] == s_op[W-1]) &
                  (add_sum[W-1] != r_op[W-1]); // [RULE_10]
   wire [W-1:0] and_res = r_op & s_op; // [RULE_13]

   wire [W-1:0] alu_f = is_abs ? abs_res :
                        (is_and ? and_res : add_sum);

   // same-cycle result shifter, only for the nibble-pair group
   wire do_sll = shiftable & (sh_code == alu_pkg::SH_SLL);
   wire do_srl = shiftable & (sh_code == alu_pkg::SH_SRL);
   wire do_sra = shiftable & (sh_code == alu_pkg::SH_SRA);
   wire [W-1:0] y_sh = do_sll ? {alu_f[W-2:0], 1'b0} :
                       do_srl ? {1'b0, alu_f[W-1:1]} :
                       do_sra ? {alu_f[W-1], alu_f[W-1:1]} :
                       alu_f; // [RULE_03] [RULE_16]
   wire sh_ovr = do_sll & (alu_f[W-1] ^ alu_f[W-2]); // [RULE_09]
   wire [W-1:0] mq_sh = (shiftable & (sh_code == alu_pkg::SH_MQ_ROL)) ?
                        {alu_f[W-2:0], alu_f[W-1]} : alu_f; // [RULE_08]

   // flags: carry before shift, zero and negative after
   wire f_zero = y_sh == '0; // [RULE_09] [RULE_10] [RULE_15]
   wire f_neg = is_abs ? s_op[W-1] : y_sh[W-1]; // [RULE_09] [RULE_15]
   wire f_ovr = is_abs ? abs_ovr :
                is_and ? sh_ovr : (add_ovr | sh_ovr); // [RULE_09] [RULE_10]
   wire f_carry = is_abs ? (s_op == '0) :
                  is_and ? 1'b0 : add_c; // [RULE_15] [RULE_10]
   wire [alu_pkg::FLAG_W-1:0] flags_nxt =
      {is_abs & s_op[W-1], f_carry, f_ovr, f_neg, f_zero};

   // events; set wins over a write-one clear in the same cycle
   wire [alu_pkg::IRQ_W-1:0] ev;
   assign ev[alu_pkg::EV_DONE] = exec_r & legal;
   assign ev[alu_pkg::EV_OVR] = exec_r & legal & f_ovr;
   assign ev[alu_pkg::EV_ILLEGAL] = exec_r & ~legal;
   assign ev[alu_pkg::EV_CFG] = exec_r & (cfg != alu_pkg::CFG_WORD32); // [RULE_14]
   wire [alu_pkg::IRQ_W-1:0] clr =
      (wr & hit_stat) ? pwdata[alu_pkg::IRQ_W-1:0] : '0;
   wire [alu_pkg::IRQ_W-1:0] irq_stat_nxt = (irq_stat_r & ~clr) | ev;

   // bus handshake: one wait state, answer registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end else begin
         pready_r <= acc;
         pslverr_r <= acc & ~mapped;
         prdata_r <= (acc & ~pwrite) ? rd_mux : '0;
      end
   end

   // software-written registers; a ctrl write starts one execution
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= alu_pkg::CTRL_RST;
         a_data_r <= '0;
         b_data_r <= '0;
         rf_word_r <= '0;
         irq_mask_r <= '0;
         exec_r <= 1'b0;
      end else begin
         if (wr & hit_ctrl) ctrl_r <= pwdata[alu_pkg::CTRL_W-1:0];
         if (wr & hit_rdata) a_data_r <= pwdata;
         if (wr & hit_sdata) b_data_r <= pwdata;
         if (wr & hit_rf) rf_word_r <= pwdata;
         if (wr & hit_mask) irq_mask_r <= pwdata[alu_pkg::IRQ_W-1:0];
         exec_r <= wr & hit_ctrl;
      end
   end

   // datapath results and status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_r <= '0;
         flags_r <= '0;
         mq_r <= '0;
         irq_stat_r <= '0;
         irq_r <= 1'b0;
         sign_r <= 1'b0;
      end else begin
         if (exec_r & legal) begin
            result_r <= y_sh;
            flags_r <= flags_nxt;
            sign_r <= is_abs & s_op[W-1]; // [RULE_06]
         end
         if (exec_r & shiftable & ld_mq) mq_r <= mq_sh; // [RULE_08] [RULE_13]
         else if (wr & hit_mq) mq_r <= pwdata;
         irq_stat_r <= irq_stat_nxt;
         irq_r <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
   assign sign_shift_flag_pin = sign_r;

   // checks
   a_abs_select: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_abs |=> result_r == ($past(s_op[W-1]) ?
         (~$past(s_op) + W'($past(cin))) : $past(s_op)))
      else $error("abs result wrong"); // [RULE_04]
   a_abs_sign: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_abs |=> sign_shift_flag_pin == $past(s_op[W-1]))
      else $error("abs sign pin wrong"); // [RULE_06]
   a_abs_ovr: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_abs && s_op == 32'h80000000 |=> flags_r[alu_pkg::FL_OVR])
      else $error("abs overflow missed"); // [RULE_07]
   a_add_sum: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_add && sh_code == 4'hF
      |=> result_r == $past(r_op) + $past(s_op) + W'($past(cin)))
      else $error("add sum wrong"); // [RULE_08]
   a_add_immediate_op_imm: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_add_immediate_op
      |=> result_r == W'($past(low_a)) + $past(s_op) + W'($past(cin)))
      else $error("add immediate wrong"); // [RULE_12]
   a_and_res: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_and && sh_code == 4'hF
      |=> result_r == ($past(a_data_r) & $past(s_op)))
      else $error("and result wrong"); // [RULE_13]
   a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && legal |=> flags_r[alu_pkg::FL_ZERO] == (result_r == '0))
      else $error("zero flag wrong"); // [RULE_10]
   a_carry_abs: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_abs |=> flags_r[alu_pkg::FL_CARRY] == ($past(s_op) == '0))
      else $error("abs carry wrong"); // [RULE_15]
   a_noshift_abs: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && (is_abs || is_add_immediate_op) |-> y_sh == alu_f)
      else $error("abs or add_immediate_op shifted"); // [RULE_16]
   a_sll_shift: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_add && sh_code == alu_pkg::SH_SLL
      |=> result_r == {$past(add_sum[W-2:0]), 1'b0})
      else $error("left shift wrong"); // [RULE_03]
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq == |($past(irq_stat_nxt) & $past(irq_mask_r)))
      else $error("irq level wrong");
   // bus answer shape: one-cycle pulses, data only in the answer cycle
   a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("pready longer than one cycle");
   a_slverr_pair: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == '0)
      else $error("read data outside answer");
   // flags: abs takes n from its input, shiftable ops from the shifted word
   a_abs_neg: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_abs |=> flags_r[alu_pkg::FL_NEG] == $past(s_op[W-1]))
      else $error("abs negative flag wrong"); // [RULE_15]
   a_neg_after: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && shiftable |=> flags_r[alu_pkg::FL_NEG] == result_r[W-1])
      else $error("negative flag not after shift"); // [RULE_09]
   a_and_carry: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_and |=> !flags_r[alu_pkg::FL_CARRY])
      else $error("and carry set"); // [RULE_09]
   // immediate is at most 15, so its sign bit is always clear
   a_add_immediate_op_ovr: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_add_immediate_op |=> flags_r[alu_pkg::FL_OVR] ==
         (!$past(s_op[W-1]) && result_r[W-1]))
      else $error("add immediate overflow wrong"); // [RULE_10]
   a_add_immediate_op_carry: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_add_immediate_op
      |=> flags_r[alu_pkg::FL_CARRY] == (result_r < $past(s_op)))
      else $error("add immediate carry wrong"); // [RULE_11]
   a_sra_shift: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && is_add && sh_code == alu_pkg::SH_SRA
      |=> result_r == {$past(add_sum[W-1]), $past(add_sum[W-1:1])})
      else $error("arithmetic shift wrong"); // [RULE_03]
   // mq gets the unshifted word unless the rotate code is given
   a_mq_plain: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && shiftable && ld_mq && sh_code != alu_pkg::SH_MQ_ROL
      |=> mq_r == $past(alu_f))
      else $error("mq load wrong"); // [RULE_08]
   a_mq_rotate: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && shiftable && ld_mq && sh_code == alu_pkg::SH_MQ_ROL
      |=> mq_r == {$past(alu_f[W-2:0]), $past(alu_f[W-1])})
      else $error("mq rotate wrong"); // [RULE_08]
   a_sign_clear: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && legal && !is_abs |=> !sign_shift_flag_pin)
      else $error("sign pin left high"); // [RULE_06]
   a_illegal_keep: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && !legal |=> $stable(result_r))
      else $error("illegal op changed result"); // [RULE_02]
   a_cfg_event: assert property (@(posedge pclk) disable iff (!presetn)
      exec_r && cfg != alu_pkg::CFG_WORD32 |=> irq_stat_r[alu_pkg::EV_CFG])
      else $error("config event missed"); // [RULE_14]
   a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      (|ev) |=> (irq_stat_r & $past(ev)) == $past(ev))
      else $error("status event lost");
   c_abs_neg: cover property (@(posedge pclk) exec_r && is_abs && s_op[W-1]);
   c_add_carry: cover property (@(posedge pclk) exec_r && is_add && add_c);
   c_and_shift: cover property (@(posedge pclk) exec_r && is_and && do_srl);
   c_irq_up: cover property (@(posedge pclk) $rose(irq));
   c_mq_rotate: cover property (@(posedge pclk)
      exec_r && ld_mq && shiftable && sh_code == alu_pkg::SH_MQ_ROL);
endmodule : alu_core

// [design/alu_pkg.sv]
// constants for the registered alu slice: map, fields, opcodes, codes
package alu_pkg;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 8;
   // register byte addresses
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_RDATA = 8'h04;
   localparam logic [7:0] OFF_SDATA = 8'h08;
   localparam logic [7:0] OFF_RFWORD = 8'h0C;
   localparam logic [7:0] OFF_RESULT = 8'h10;
   localparam logic [7:0] OFF_FLAGS = 8'h14;
   localparam logic [7:0] OFF_MQ = 8'h18;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
   // control word fields
   localparam int unsigned CTRL_W = 19;
   localparam int unsigned F_OP_LO = 0;
   localparam int unsigned F_OP_HI = 7;
   localparam int unsigned F_CIN = 8;
   localparam int unsigned F_SSEL_LO = 9;
   localparam int unsigned F_SSEL_HI = 10;
   localparam int unsigned F_CFG_LO = 11;
   localparam int unsigned F_CFG_HI = 13;
   localparam int unsigned F_IMM_LO = 14;
   localparam int unsigned F_IMM_HI = 17;
   localparam int unsigned F_LDMQ = 18;
   localparam logic [CTRL_W-1:0] CTRL_RST = 19'h03000;
   // full-byte opcodes
   localparam logic [7:0] OP_ABS = 8'h48;
   localparam logic [7:0] OP_ADD_IMMEDIATE_OP = 8'h68;
   // low-nibble alu opcodes
   localparam logic [3:0] ALU_ADD = 4'h1;
   localparam logic [3:0] ALU_AND = 4'hA;
   // upper-nibble shift codes
   localparam logic [3:0] SH_MQ_ROL = 4'hD;
   localparam logic [3:0] SH_SLL = 4'hC;
   localparam logic [3:0] SH_SRL = 4'hB;
   localparam logic [3:0] SH_SRA = 4'hA;
   // s operand sources
   localparam logic [1:0] SSEL_RF = 2'h0;
   localparam logic [1:0] SSEL_DB = 2'h1;
   localparam logic [1:0] SSEL_MQ = 2'h2;
   localparam logic [2:0] CFG_WORD32 = 3'h6;
   localparam logic [7:0] MS_BYTE_MIN = 8'h80;
   localparam logic [23:0] LOW_BYTES_ZERO = 24'h000000;
   // flag and interrupt bit positions
   localparam int unsigned FL_ZERO = 0;
   localparam int unsigned FL_NEG = 1;
   localparam int unsigned FL_OVR = 2;
   localparam int unsigned FL_CARRY = 3;
   localparam int unsigned FL_SIGN = 4;
   localparam int unsigned FLAG_W = 5;
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned EV_DONE = 0;
   localparam int unsigned EV_OVR = 1;
   localparam int unsigned EV_ILLEGAL = 2;
   localparam int unsigned EV_CFG = 3;
endpackage : alu_pkg

// [sim/useq_model.sv]
// apb master standing in for the microsequencer that issues control words
`timescale 1ns/10ps
module useq_model (
   input wire logic pclk, // bus clock
   output logic psel, // select
   output logic penable, // access phase
   output logic pwrite, // direction
   output logic [alu_pkg::ADDR_W-1:0] paddr, // byte address
   output logic [alu_pkg::DATA_W-1:0] pwdata, // write data
   input wire logic [alu_pkg::DATA_W-1:0] prdata, // read data
   input wire logic pready, // end of access
   input wire logic pslverr // unmapped address
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines flip so a stale value never passes as a live one
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask : xfer
   task automatic issue(input logic [7:0] op, input logic c,
      input logic [1:0] ss, input logic [3:0] im);
      logic [31:0] q;
      logic e;
      logic cin;
      cin = (op == alu_pkg::OP_ABS) ? 1'b1 : c;
      xfer(1'b1, alu_pkg::OFF_CTRL, {13'h0, 1'b0, im,
         alu_pkg::CFG_WORD32, ss, cin, op}, q, e);
   endtask : issue
endmodule : useq_model

// [sim/tb_top.sv]
// self-checking bench for the alu slice behind its apb registers
`timescale 1ns/10ps
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sflag, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   int err_count = 0;
   int cmp_count = 0;
   alu_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sign_shift_flag_pin(sflag), .irq(irq));
   useq_model i_useq (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      i_useq.xfer(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      i_useq.xfer(1'b0, a, 32'h0, q, e);
   endtask : rd
   // only the chosen s source holds s, the others its inverse
   task automatic run(input logic [7:0] op, input logic c,
      input logic [1:0] ss, input logic [3:0] im, input logic [31:0] r,
      input logic [31:0] s, input logic [31:0] res, input logic [4:0] fl);
      logic [31:0] q;
      wr(alu_pkg::OFF_RDATA, r);
      wr(alu_pkg::OFF_RFWORD, ss == 2'h0 ? s : ~s);
      wr(alu_pkg::OFF_SDATA, ss == 2'h1 ? s : ~s);
      wr(alu_pkg::OFF_MQ, ss == 2'h2 ? s : ~s);
      i_useq.issue(op, c, ss, im);
      rd(alu_pkg::OFF_RESULT, q);
      chk(q, res);
      rd(alu_pkg::OFF_FLAGS, q);
      chk(q, {27'h0, fl});
      chk({31'h0, sflag}, {31'h0, fl[4]});
   endtask : run
   task automatic t_abs;
      run(8'h48, 1, 0, 0, 0, 32'hF6D81340, 32'h0927ECC0, 5'h12);
      run(8'h48, 1, 1, 0, 0, 32'h09D527C0, 32'h09D527C0, 5'h00);
      run(8'h48, 1, 2, 0, 0, 32'h80000000, 32'h80000000, 5'h16);
      run(8'h48, 1, 1, 0, 0, 32'h80000100, 32'h7FFFFF00, 5'h12);
      run(8'h48, 1, 1, 0, 0, 32'h0, 32'h0, 5'h09);
   endtask : t_abs
   task automatic t_add;
      run(8'hE1, 0, 1, 0, 32'h0802C618, 32'h1E007530, 32'h26033B48, 5'h00);
      run(8'hF1, 1, 0, 0, 32'h0802C618, 32'h1E007530, 32'h26033B49, 5'h00);
      run(8'hF1, 0, 0, 0, 32'h7FFFFFFF, 32'h1, 32'h80000000, 5'h06);
      run(8'hC1, 0, 1, 0, 32'hFFFFFFFF, 32'h1, 32'h0, 5'h09);
      run(8'hB1, 0, 2, 0, 32'h80000000, 32'h0, 32'h40000000, 5'h00);
      run(8'hA1, 0, 1, 0, 32'h80000000, 32'h0, 32'hC0000000, 5'h02);
   endtask : t_add
   task automatic t_add_immediate_op;
      run(8'h68, 0, 1, 4'hC, 32'h12345678, 32'h24000100, 32'h2400010C, 5'h00);
      run(8'h68, 1, 0, 4'hF, 32'h12345678, 32'hFFFFFFF0, 32'h0, 5'h09);
   endtask : t_add_immediate_op
   task automatic t_and;
      run(8'hFA, 0, 0, 0, 32'hF617D840, 32'h15F6D842, 32'h1416D840, 5'h00);
      run(8'hCA, 0, 1, 0, 32'hF617D840, 32'h15F6D842, 32'h282DB080, 5'h00);
      run(8'hBA, 0, 2, 0, 32'h80000001, 32'hFFFFFFFF, 32'h40000000, 5'h00);
   endtask : t_and
   task automatic t_irq;
      logic [31:0] q;
      wr(alu_pkg::OFF_IRQ_STAT, 32'hF);
      wr(alu_pkg::OFF_IRQ_MASK, 32'h4);
      i_useq.issue(8'h00, 0, 0, 0);
      rd(alu_pkg::OFF_RESULT, q);
      chk(q, 32'h40000000);
      rd(alu_pkg::OFF_IRQ_STAT, q);
      chk(q, 32'h4);
      chk({31'h0, irq}, 32'h1);
      wr(alu_pkg::OFF_IRQ_STAT, 32'h4);
      i_useq.issue(8'hFA, 0, 0, 0);
      rd(alu_pkg::OFF_IRQ_STAT, q);
      chk(q, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(alu_pkg::OFF_IRQ_MASK, 32'h1);
      rd(alu_pkg::OFF_IRQ_MASK, q);
      chk({31'h0, irq}, 32'h1);
   endtask : t_irq
   task automatic t_mq;
      logic [31:0] q;
      wr(alu_pkg::OFF_IRQ_STAT, 32'hF);
      wr(alu_pkg::OFF_RDATA, 32'h00000003);
      wr(alu_pkg::OFF_SDATA, 32'h40000001);
      // load mq with rotate, byte-lane config only raises its event
      wr(alu_pkg::OFF_CTRL, {13'h0, 1'b1, 4'h0, 3'h0, 2'h1, 1'b0, 8'hD1});
      rd(alu_pkg::OFF_MQ, q);
      chk(q, 32'h80000008);
      rd(alu_pkg::OFF_RESULT, q);
      chk(q, 32'h40000004);
      rd(alu_pkg::OFF_IRQ_STAT, q);
      chk(q, 32'h9);
   endtask : t_mq
   task automatic t_bus;
      logic [31:0] q;
      logic e;
      i_useq.xfer(1'b0, 8'h40, 32'h0, q, e);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
   endtask : t_bus
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict
   initial begin
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_abs;
      t_add;
      t_add_immediate_op;
      t_and;
      t_irq;
      t_mq;
      t_bus;
      print_verdict;
   end
   // the run needs a few microseconds; a stuck handshake ends here
   initial begin
      #50000;
      err_count++;
      print_verdict;
   end
endmodule : tb_top
